// ==== rtl/rxpp_fcs.sv ====
`timescale 1ns/1ps
module rxpp_fcs
  import rxpp_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clear,
  input  wire logic bit_valid,
  input  wire logic bit_in,
  input  wire logic wide,
  output logic      crc_ok
);

  typedef struct packed {
    logic [31:0] crc;
  } rxpp_fcs_s;

  rxpp_fcs_s st;
  rxpp_fcs_s next_st;

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic        b,
                                           input logic [31:0] poly);
    logic fb;
    fb = c[0] ^ b;
    crc_step = (c >> 1) ^ (fb ? poly : 32'h00000000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // in 16-bit mode the upper half is held at zero so no bits leak down
  always_comb
  begin
    next_st = st;
    if (clear)
    begin
      next_st.crc = FCS_INIT;
    end
    else if (bit_valid)
    begin
      next_st.crc = wide ? crc_step(st.crc, bit_in, FCS_POLY32)               // [R2]
                         : crc_step({16'h0000, st.crc[15:0]}, bit_in, FCS_POLY16);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st.crc <= FCS_INIT;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign crc_ok = wide ? (st.crc == FCS_RES32) : (st.crc[15:0] == FCS_RES16); // [R2]

endmodule

// ==== rtl/rxpp_top.sv ====
`timescale 1ns/1ps
module rxpp_top
  import rxpp_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rx_bit_valid,
  input  wire logic              rx_bit,
  input  wire logic              rx_eop,
  input  wire logic              rx_abort,
  output logic [7:0]             fifo_byte,
  output logic                   fifo_valid,
  output logic                   fifo_sop,
  output logic                   fifo_eop,
  output logic                   fifo_bad,
  output logic                   irq
);

  typedef struct packed {
    rxpp_rx_e                       rx;
    logic [7:0]                     ctl1;
    logic [7:0]                     min_size;
    logic [15:0]                    max_size;
    logic [7:0]                     irq_en;
    logic [7:0]                     latched;
    logic [CNT_N-1:0][CNT_W-1:0]    cnt;
    logic [CNT_N-1:0][15:0]         snap;
    logic [SCR_LEN-1:0]             scr;
    logic [7:0]                     sh;
    logic [2:0]                     bitcnt;
    logic [15:0]                    len;
    logic [3:0][7:0]                hold;
    logic [2:0]                     hold_cnt;
    logic                           sop_pend;
    logic [7:0]                     out_byte;
    logic                           out_valid;
    logic                           out_sop;
    logic                           out_eop;
    logic                           out_bad;
    logic                           aw_full;
    logic [ADDR_W-1:0]              awaddr;
    logic                           w_full;
    logic [7:0]                     wdata;
    logic                           wstrb0;
    logic                           bvalid;
    logic                           rvalid;
    logic [7:0]                     rdata;
  } rxpp_state_s;

  rxpp_state_s st;
  rxpp_state_s next_st;

  logic        crc_ok;
  logic        cc;
  logic        fcs_on;
  logic        d_bit;
  logic        byte_done;
  logic        pkt_end;
  logic        discard_all;
  logic        ev_abort;
  logic        ev_size;
  logic        ev_fcs;
  logic        ev_good;
  logic        partial;
  logic        runt;
  logic        giant;
  logic [15:0] eff_min;
  logic [2:0]  depth;
  logic [2:0]  live;
  logic [7:0]  clr_vec;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [2:0] fcs_depth(input logic [7:0] c);
    if (c[B_CLEAR_CH] || c[B_FCS_OFF] || c[B_KEEP])
      fcs_depth = 3'h0;                                                       // [R3]
    else
      fcs_depth = c[B_SHORT] ? DEPTH_FCS16 : DEPTH_FCS32;
  endfunction

  function automatic logic [7:0] rd_byte(input rxpp_state_s s,
                                         input logic [IDX_W-1:0] idx,
                                         input logic [2:0] lv);
    logic [IDX_W-1:0] off;
    logic [1:0]       k;
    off     = IDX_W'(idx - IDX_CNT_BASE);
    k       = off[3:2];
    rd_byte = 8'h00;
    if (idx == IDX_CTL1)
      rd_byte = s.ctl1 & CTL1_WMASK;
    else if (idx == IDX_MIN)
      rd_byte = s.min_size;
    else if (idx == IDX_MAX_LO)
      rd_byte = s.max_size[7:0];
    else if (idx == IDX_MAX_HI)
      rd_byte = s.max_size[15:8];
    else if (idx == IDX_LIVE)
      rd_byte = {5'h00, lv};                                                  // [R12]
    else if (idx == IDX_LATCHED)
      rd_byte = s.latched;
    else if (idx == IDX_IRQ_EN)
      rd_byte = s.irq_en;
    else if (idx >= IDX_CNT_BASE && idx < IDX_CNT_END && off[1:0] != CNT_BYTE_GAP)
    begin
      unique case (off[1:0])
        2'h0:    rd_byte = s.cnt[k][7:0];
        2'h1:    rd_byte = s.snap[k][7:0];                                    // [R23]
        default: rd_byte = s.snap[k][15:8];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // packet decisions

  assign cc          = st.ctl1[B_CLEAR_CH];                                   // [R6]
  assign fcs_on      = !st.ctl1[B_FCS_OFF];                                   // [R1]
  assign d_bit       = st.ctl1[B_DESCR_OFF] ? rx_bit : rx_bit ^ st.scr[SCR_LEN-1]; // [R4]
  assign byte_done   = rx_bit_valid && (st.bitcnt == 3'h7);
  assign depth       = fcs_depth(st.ctl1);
  assign pkt_end     = !cc && (st.rx == RX_PKT) && (rx_eop || rx_abort);
  assign eff_min     = ({8'h00, st.min_size} > (fcs_on ? (st.ctl1[B_SHORT] ? FLOOR_FCS16
                       : FLOOR_FCS32) : FLOOR_NO_FCS)) ? {8'h00, st.min_size}
                       : (fcs_on ? (st.ctl1[B_SHORT] ? FLOOR_FCS16 : FLOOR_FCS32)
                       : FLOOR_NO_FCS);                                       // [R7] [R8]
  assign partial     = st.bitcnt != 3'h0;
  assign runt        = st.len < eff_min;                                      // [R7]
  assign giant       = st.len > st.max_size;                                  // [R9]
  assign discard_all = st.max_size < {8'h00, st.min_size};                    // [R10]
  assign ev_abort    = pkt_end && rx_abort;
  assign ev_size     = pkt_end && !rx_abort && (partial || runt || giant);
  assign ev_fcs      = pkt_end && !rx_abort && !ev_size && fcs_on && !crc_ok; // [R1]
  assign ev_good     = pkt_end && !rx_abort && !ev_size && !ev_fcs && !discard_all;
  assign live        = {st.cnt[CNT_FCS] != '0, st.cnt[CNT_ABORT] != '0,
                        st.cnt[CNT_SIZE] != '0};                              // [R12]
  assign clr_vec     = (st.aw_full && st.w_full && !st.bvalid && st.wstrb0 &&
                        st.awaddr[ADDR_W-1:2] == IDX_LATCHED) ? st.wdata : 8'h00;

  rxpp_fcs u_fcs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (pkt_end || cc),
    .bit_valid (rx_bit_valid && !cc),
    .bit_in    (d_bit),
    .wide      (!st.ctl1[B_SHORT]),
    .crc_ok    (crc_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [7:0]       nb;
    logic [7:0]       set_vec;
    logic [IDX_W-1:0] ridx;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] roff;
    nb                = 8'h00;
    set_vec           = 8'h00;
    ridx              = s_axi_araddr[ADDR_W-1:2];
    widx              = st.awaddr[ADDR_W-1:2];
    roff              = IDX_W'(ridx - IDX_CNT_BASE);
    next_st           = st;
    next_st.out_valid = 1'b0;
    next_st.out_sop   = 1'b0;
    next_st.out_eop   = 1'b0;
    next_st.out_bad   = 1'b0;

    // line side: descrambler history runs on raw received bits
    if (rx_bit_valid)
    begin
      next_st.scr    = {st.scr[SCR_LEN-2:0], rx_bit};                         // [R4]
      next_st.sh     = st.ctl1[B_REVERSE] ? {d_bit, st.sh[7:1]}
                                          : {st.sh[6:0], d_bit};              // [R5]
      next_st.bitcnt = 3'(st.bitcnt + 3'h1);
      if (st.rx == RX_IDLE && !cc)
      begin
        next_st.rx       = RX_PKT;
        next_st.sop_pend = 1'b1;
      end
    end
    nb = next_st.sh;

    if (byte_done)
    begin
      if (st.len != 16'hFFFF)
        next_st.len = 16'(st.len + 16'h0001);
      // trailing check bytes wait in the hold line until the packet ends
      if (st.hold_cnt == depth)
      begin
        next_st.out_valid = 1'b1;                                             // [R3]
        next_st.out_byte  = (depth == 3'h0) ? nb : st.hold[2'(depth - 3'h1)];
        next_st.out_sop   = st.sop_pend;
        next_st.sop_pend  = 1'b0;
      end
      else
      begin
        next_st.hold_cnt = 3'(st.hold_cnt + 3'h1);
      end
      next_st.hold = {st.hold[2:0], nb};
      if (cc)
      begin
        next_st.out_sop = st.sop_pend || (st.len == 16'h0000);
        if (16'(st.len + 16'h0001) >= st.max_size)
        begin
          next_st.out_eop  = 1'b1;                                            // [R11]
          next_st.len      = 16'h0000;
          next_st.sop_pend = 1'b1;
        end
      end
    end

    if (pkt_end)
    begin
      next_st.out_eop  = 1'b1;
      next_st.out_bad  = rx_abort || ev_size || ev_fcs || discard_all;        // [R10]
      next_st.rx       = RX_IDLE;
      next_st.len      = 16'h0000;
      next_st.bitcnt   = 3'h0;
      next_st.hold_cnt = 3'h0;                                                // [R3]
      next_st.sop_pend = 1'b0;
    end
    if (cc)
      next_st.rx = RX_IDLE;

    // event counters wrap, live bits follow them
    if (ev_good)
      next_st.cnt[CNT_GOOD] = CNT_W'(st.cnt[CNT_GOOD] + 24'h000001);          // [R17]
    if (ev_fcs)
      next_st.cnt[CNT_FCS] = CNT_W'(st.cnt[CNT_FCS] + 24'h000001);            // [R19]
    if (ev_abort)
      next_st.cnt[CNT_ABORT] = CNT_W'(st.cnt[CNT_ABORT] + 24'h000001);        // [R20]
    if (ev_size)
      next_st.cnt[CNT_SIZE] = CNT_W'(st.cnt[CNT_SIZE] + 24'h000001);          // [R21]

    set_vec[L_FCS_ERR]    = ev_fcs;                                           // [R13]
    set_vec[L_ABORT]      = ev_abort;
    set_vec[L_PARTIAL]    = ev_size && partial;
    set_vec[L_RUNT]       = ev_size && runt;
    set_vec[L_GIANT]      = ev_size && giant;
    set_vec[L_FCS_RISE]   = (next_st.cnt[CNT_FCS] != '0) && (st.cnt[CNT_FCS] == '0); // [R14]
    set_vec[L_ABORT_RISE] = (next_st.cnt[CNT_ABORT] != '0) && (st.cnt[CNT_ABORT] == '0);
    set_vec[L_SIZE_RISE]  = (next_st.cnt[CNT_SIZE] != '0) && (st.cnt[CNT_SIZE] == '0);
    // a set in the clearing cycle survives
    next_st.latched = (st.latched & ~clr_vec) | set_vec;                      // [R22]

    // bus: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_full = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_full = 1'b1;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.aw_full && st.w_full && !st.bvalid)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      if (st.wstrb0)
      begin
        if (widx == IDX_CTL1)
          next_st.ctl1 = st.wdata & CTL1_WMASK;
        else if (widx == IDX_MIN)
          next_st.min_size = st.wdata;                                        // [R7]
        else if (widx == IDX_MAX_LO)
          next_st.max_size[7:0] = st.wdata;                                   // [R9]
        else if (widx == IDX_MAX_HI)
          next_st.max_size[15:8] = st.wdata;
        else if (widx == IDX_IRQ_EN)
          next_st.irq_en = st.wdata;                                          // [R15]
      end
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_byte(st, ridx, live);
      if (ridx >= IDX_CNT_BASE && ridx < IDX_CNT_END && roff[1:0] == 2'h0)
        next_st.snap[roff[3:2]] = st.cnt[roff[3:2]][CNT_W-1:8];               // [R23]
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st          <= '0;
      st.rx       <= RX_IDLE;
      st.ctl1     <= RST_CTL1;
      st.min_size <= RST_MIN;
      st.max_size <= RST_MAX;                                                 // [R9]
      st.irq_en   <= RST_IRQ_EN;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = !st.aw_full && !st.bvalid;
  assign s_axi_wready  = !st.w_full && !st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = AXI_OKAY;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = {24'h000000, st.rdata};
  assign s_axi_rresp   = AXI_OKAY;
  assign fifo_byte     = st.out_byte;
  assign fifo_valid    = st.out_valid;
  assign fifo_sop      = st.out_sop;
  assign fifo_eop      = st.out_eop;
  assign fifo_bad      = st.out_bad;
  assign irq           = |(st.latched & st.irq_en);                           // [R15] [R22]

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_good_count: assert property (ev_good |=> st.cnt[CNT_GOOD] == $past(st.cnt[CNT_GOOD]) + 24'h000001) // [R17]
    else $error("good packet count did not advance");
  a_fcs_count: assert property (ev_fcs |=> st.cnt[CNT_FCS] == $past(st.cnt[CNT_FCS]) + 24'h000001 && st.latched[L_FCS_ERR]) // [R19]
    else $error("fcs error not counted or latched");
  a_abort_latch: assert property (ev_abort |=> st.latched[L_ABORT] ##0 fifo_eop && fifo_bad) // [R20]
    else $error("abort not latched or not marked");
  a_runt_detect: assert property (pkt_end && !rx_abort && st.len < FLOOR_NO_FCS |=> st.latched[L_RUNT]) // [R8]
    else $error("packet below floor not flagged");
  a_latch_sticky: assert property (##1 ($past(st.latched) & ~$past(clr_vec) & ~st.latched) == 8'h00) // [R22]
    else $error("latched bit dropped without clear");
  a_rise_latch: assert property ($rose(st.cnt[CNT_SIZE] != '0) |-> st.latched[L_SIZE_RISE]) // [R14]
    else $error("size count rise not latched");
  a_discard_all: assert property (pkt_end && discard_all |=> fifo_eop && fifo_bad) // [R10]
    else $error("packet kept while max below min");
  a_irq_gate: assert property (st.latched == 8'h00 |-> !irq) // [R15]
    else $error("interrupt without latched cause");
  a_clear_chunk: assert property (cc && $past(cc) && fifo_eop |-> !fifo_bad && fifo_valid) // [R11]
    else $error("clear channel chunk end malformed");
  a_bvalid_hold: assert property (st.bvalid && !s_axi_bready |=> st.bvalid)
    else $error("write response dropped early");

  c_good_pkt: cover property (fifo_eop && !fifo_bad && !cc);
  c_fcs_err: cover property (ev_fcs);
  c_irq: cover property ($rose(irq));
  c_chunk: cover property (cc && fifo_eop);

endmodule

// ==== shared/rxpp_pkg.sv ====
// How it works
// R1: check_sequence_off set skips all FCS checking
// R2: short_check_select picks 16-bit, else 32-bit
// R3: check_bytes_keep clear strips FCS bytes
// R4: descramble unless descramble_off is set
// R5: bit_order_reverse puts first bit in LSB
// R6: clear channel keeps only descramble and reorder
// R7: programmed minimum packet length incl. FCS bytes
// R8: floor minimum six, four or two bytes
// R9: 16-bit maximum length, resets to 0x0600
// R10: maximum below minimum discards every packet
// R11: clear channel cuts chunks of maximum length
// R12: live bits show counters non-zero
// R13: latch five per-packet error events
// R14: latch counter non-zero rising edges only
// R15: enable bit per latched bit gates interrupt
// R16: software masks count irq without FCS
// R17: 24-bit count of non-aborted stored packets
// R18: software writes zero to control bit six
// R19: 24-bit count of FCS errored packets
// R20: 24-bit count of aborted packets
// R21: 24-bit count of size violation packets
// R22: latched bits sticky, irq ORs enabled ones
// R23: counter bytes read from consistent snapshot
package rxpp_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          IDX_W         = 14;
  localparam int          CNT_W         = 24;
  localparam int          CNT_N         = 4;
  localparam int          SCR_LEN       = 43;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [13:0] IDX_CTL1      = 14'h1000;
  localparam logic [13:0] IDX_MIN       = 14'h1001;
  localparam logic [13:0] IDX_MAX_LO    = 14'h1002;
  localparam logic [13:0] IDX_MAX_HI    = 14'h1003;
  localparam logic [13:0] IDX_LIVE      = 14'h100F;
  localparam logic [13:0] IDX_LATCHED   = 14'h1011;
  localparam logic [13:0] IDX_IRQ_EN    = 14'h1013;
  localparam logic [13:0] IDX_CNT_BASE  = 14'h1014;
  localparam logic [13:0] IDX_CNT_END   = 14'h1024;
  localparam logic [1:0]  CNT_BYTE_GAP  = 2'h3;

  // counter slots, in address order
  localparam logic [1:0]  CNT_GOOD      = 2'h0;
  localparam logic [1:0]  CNT_FCS       = 2'h1;
  localparam logic [1:0]  CNT_ABORT     = 2'h2;
  localparam logic [1:0]  CNT_SIZE      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // control one fields
  localparam int          B_FCS_OFF     = 5;
  localparam int          B_SHORT       = 4;
  localparam int          B_KEEP        = 3;
  localparam int          B_DESCR_OFF   = 2;
  localparam int          B_REVERSE     = 1;
  localparam int          B_CLEAR_CH    = 0;
  localparam logic [7:0]  CTL1_WMASK    = 8'hBF;

  // latched status and enable positions
  localparam int          L_FCS_ERR     = 7;
  localparam int          L_ABORT       = 6;
  localparam int          L_PARTIAL     = 5;
  localparam int          L_RUNT        = 4;
  localparam int          L_GIANT       = 3;
  localparam int          L_FCS_RISE    = 2;
  localparam int          L_ABORT_RISE  = 1;
  localparam int          L_SIZE_RISE   = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  RST_CTL1      = 8'h00;
  localparam logic [7:0]  RST_MIN       = 8'h00;
  localparam logic [15:0] RST_MAX       = 16'h0600;
  localparam logic [7:0]  RST_IRQ_EN    = 8'h00;

  // smallest packet regardless of the programmed minimum
  localparam logic [15:0] FLOOR_FCS32   = 16'h0006;
  localparam logic [15:0] FLOOR_FCS16   = 16'h0004;
  localparam logic [15:0] FLOOR_NO_FCS  = 16'h0002;
  localparam logic [2:0]  DEPTH_FCS32   = 3'h4;
  localparam logic [2:0]  DEPTH_FCS16   = 3'h2;

  // reflected check sequences, bits fed first-received first
  localparam logic [31:0] FCS_INIT      = 32'hFFFFFFFF;
  localparam logic [31:0] FCS_POLY32    = 32'hEDB88320;
  localparam logic [31:0] FCS_POLY16    = 32'h00008408;
  localparam logic [31:0] FCS_RES32     = 32'hDEBB20E3;
  localparam logic [15:0] FCS_RES16     = 16'hF0B8;

  localparam logic [1:0]  AXI_OKAY      = 2'h0;

  typedef enum logic {RX_IDLE, RX_PKT} rxpp_rx_e;

endpackage

// ==== tb/rxpp_line.sv ====
`timescale 1ns/1ps
module rxpp_line
(
  input  wire logic aclk,
  output logic      rx_bit_valid,
  output logic      rx_bit,
  output logic      rx_eop,
  output logic      rx_abort
);
  logic [42:0] h = '0;
  initial {rx_bit_valid, rx_bit, rx_eop, rx_abort} = 4'h0;
  // history runs on line bits always, so it stays in step with the device
  task automatic send(input bit q[$], input bit scr, input bit abt);
    logic b;
    b = 1'b0;
    foreach (q[i])
    begin
      @(posedge aclk);
      b = scr ? q[i] ^ h[42] : q[i];
      h = {h[41:0], b};
      rx_bit_valid <= 1'b1;
      rx_bit       <= b;
    end
    @(posedge aclk);
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~b;
    rx_eop       <= !abt;
    rx_abort     <= abt;
    @(posedge aclk);
    {rx_eop, rx_abort} <= 2'h0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import rxpp_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, seed = 32'd81380;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_bit_valid, rx_bit;
  logic              rx_eop, rx_abort, fifo_valid, fifo_sop, fifo_eop, fifo_bad, irq, eb[$];
  logic [7:0]        fifo_byte, lat = 8'h00, en, e[$], gq[$];
  int                n_fail, compares, es[$], sq[$], cnt[4];
  int tab[13][7] = '{'{36,0,1536,4,0,0,0}, '{32,0,1536,8,0,0,0}, '{4,0,1536,6,0,0,0},
    '{30,0,1536,5,0,0,0}, '{4,0,1536,6,0,0,1}, '{36,0,1536,4,0,1,0}, '{36,0,1536,1,0,0,0},
    '{4,0,1536,1,0,0,0}, '{36,5,1536,4,0,0,0}, '{36,0,1536,3,3,0,0}, '{36,0,4,5,0,0,0},
    '{36,8,4,5,0,0,0}, '{5,0,3,6,0,0,0}};
  always #5 aclk = ~aclk;
  rxpp_top i_rxpp_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_bit_valid, .rx_bit, .rx_eop, .rx_abort, .fifo_byte,
    .fifo_valid, .fifo_sop, .fifo_eop, .fifo_bad, .irq);
  rxpp_line i_rxpp_line (.aclk, .rx_bit_valid, .rx_bit, .rx_eop, .rx_abort);
  always @(posedge aclk)
  begin
    if (fifo_valid && fifo_sop) sq.push_back(gq.size());
    if (fifo_valid) gq.push_back(fifo_byte);
    if (fifo_eop) es.push_back(gq.size());
    if (fifo_eop) eb.push_back(fifo_bad);
  end
  ////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 200)
    begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      tmo(n++);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, AXI_OKAY);
  endtask
  task automatic rc(input logic [13:0] i, input logic [7:0] x);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      tmo(n++);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata[31:8]}, 32'h0);
    chk(s_axi_rdata[7:0], x);
  endtask
  ////////////////////////////////////////
  task automatic run(input int t[7]);
    bit q[$];
    logic [31:0] c, p;
    logic [7:0] b;
    int L, s, fc, mn, lb, ci, bd, k, xs[$];
    wr(IDX_CTL1, 8'(t[0]));
    wr(IDX_MIN, 8'(t[1]));
    wr(IDX_MAX_LO, 8'(t[2]));
    wr(IDX_MAX_HI, 8'(t[2] >> 8));
    fc = t[0][5] || t[0][0] ? 0 : t[0][4] ? 16 : 32;
    c = fc == 16 ? 32'hFFFF : FCS_INIT;
    p = fc == 16 ? FCS_POLY16 : FCS_POLY32;
    repeat (t[3] * 8)
    begin
      seed = nx(seed);
      q.push_back(seed[0]);
      c = (c >> 1) ^ ((c[0] ^ seed[0]) ? p : 32'h0);
    end
    for (k = 0; k < fc; k++) q.push_back(~c[k]);
    if (t[6]) q[0] = ~q[0];
    repeat (t[4]) q.push_back(1'b0);
    gq = {};
    es = {};
    eb = {};
    sq = {};
    i_rxpp_line.send(q, !t[0][2], t[5][0]);
    repeat (4) @(posedge aclk);
    L = q.size() / 8;
    s = fc > 0 && !t[0][3] ? fc / 8 : 0;
    e = {};
    for (k = 0; k < L - s; k++)
    begin
      for (int j = 0; j < 8; j++) b[t[0][1] ? j : 7 - j] = q[8 * k + j];
      e.push_back(b);
    end
    mn = fc == 32 ? 6 : fc == 16 ? 4 : 2;
    mn = t[1] > mn ? t[1] : mn;
    lb = t[5] ? L_ABORT : t[4] ? L_PARTIAL : L < mn ? L_RUNT : L > t[2] ? L_GIANT
      : t[6] ? L_FCS_ERR : -1;
    ci = lb == L_ABORT ? CNT_ABORT : lb == L_FCS_ERR ? CNT_FCS : lb >= 0 ? CNT_SIZE : 0;
    // clear channel ends no packets, so no counter or latched bit moves
    if (t[0][0])
    begin
      lb = -1;
      ci = -1;
    end
    bd = !t[0][0] && ci != CNT_GOOD;
    if (ci > 0 && cnt[ci] == 0) lat[3 - ci] = 1'b1;
    if (ci >= 0) cnt[ci]++;
    if (lb >= 0) lat[lb] = 1'b1;
    if (lb == L_RUNT && L > t[2]) lat[L_GIANT] = 1'b1;
    if (t[0][0]) for (k = t[2]; k <= L; k += t[2]) xs.push_back(k);
    else xs.push_back(e.size());
    foreach (e[i]) chk(gq[i], e[i]);
    chk(gq.size(), e.size());
    chk(es.size(), xs.size());
    foreach (xs[i]) chk(es[i], xs[i]);
    foreach (xs[i]) chk(eb[i], bd);
    chk(sq.size(), xs.size());
    foreach (sq[i]) chk(sq[i], i ? xs[i - 1] : 0);
    for (k = 0; k < 4; k++) rc(IDX_CNT_BASE + 14'(4 * k), 8'(cnt[k]));
    rc(IDX_LATCHED, lat);
    rc(IDX_LIVE, {5'h0, cnt[1] != 0, cnt[2] != 0, cnt[3] != 0});
    chk(irq, |(lat & en));
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(IDX_MAX_LO, 8'h00);
    rc(IDX_MAX_HI, 8'h06);
    rc(IDX_LIVE, 8'h00);
    rc(IDX_LATCHED, 8'h00);
    wr(14'h1004, 8'hFF);
    rc(14'h1004, 8'h00);
    en = 8'hFB;
    wr(IDX_IRQ_EN, en);
    rc(IDX_IRQ_EN, en);
    foreach (tab[r]) run(tab[r]);
    wr(IDX_IRQ_EN, 8'h00);
    chk(irq, 1'b0);
    wr(IDX_LATCHED, 8'hFF);
    rc(IDX_LATCHED, 8'h00);
    rc(IDX_CNT_BASE + 14'h1, 8'h00);
    final_report();
  end
endmodule
